/* src/pgw_pkg.sv */
package pgw_pkg;
  // Pixel and gain widths
  localparam int PIX_W = 12; // Internal and widest output depth
  localparam int GAIN_W = 14; // Gain setting width
  localparam int GAIN_FRAC = 12; // Setting / 4096 is the factor
  // Gain limits and reset values
  localparam logic [13:0] GAIN_MIN = 14'h0aab; // 2731, -3.5 dB
  localparam logic [13:0] GAIN_UNITY = 14'h1000; // 4096, 0 dB
  localparam logic [13:0] GAIN_NORM_MAX = 14'h2000; // 8192, +6 dB
  localparam logic [13:0] GAIN_MAX = 14'h3fff; // 16383, +12 dB
  localparam logic [13:0] GAIN_RST = 14'h1000; // Global gain after reset
  localparam logic [13:0] RED_RST = 14'h1000; // Red gain after reset
  localparam logic [13:0] GREEN_RST = 14'h1800; // Green gain after reset
  localparam logic [13:0] BLUE_RST = 14'h2000; // Blue gain after reset
  localparam logic [11:0] DB_RST = 12'h000; // 0 dB in 1/16 dB steps
  // dB to factor conversion, dB held in 1/16 dB steps
  localparam logic [21:0] DB_TO_LOG2 = 22'h0002a8; // 680/16 = 4096/6.0206/16
  localparam logic [10:0] MANT_B = 11'h57f; // 1407, curvature of 2^f
  localparam logic [12:0] MANT_A = 13'h0a81; // 2689, slope of 2^f
  // Output depth modes
  typedef enum logic [1:0] {MODE_8, MODE_10, MODE_12} pgw_mode_t;
  localparam logic [1:0] MODE_RST = 2'h0; // 8-bit output after reset
  // Offset limits per mode, in setting units
  localparam logic [12:0] OFS_LIM_8 = 13'h00ff; // 255
  localparam logic [12:0] OFS_LIM_10 = 13'h03ff; // 1023
  localparam logic [12:0] OFS_LIM_12 = 13'h0fff; // 4095
  localparam logic [3:0] SHIFT_8 = 4'h4; // 16 units per count
  localparam logic [3:0] SHIFT_10 = 4'h2; // 4 units per count
  localparam logic [3:0] SHIFT_12 = 4'h0; // 1 unit per count
  localparam logic [11:0] PIX_MAX = 12'hfff; // 12-bit full scale
  // Register byte offsets
  localparam logic [7:0] ADR_GAIN_RAW = 8'h00;
  localparam logic [7:0] ADR_GAIN_DB = 8'h04;
  localparam logic [7:0] ADR_OFS_RAW = 8'h08;
  localparam logic [7:0] ADR_OFS_DN = 8'h0c;
  localparam logic [7:0] ADR_RED = 8'h10;
  localparam logic [7:0] ADR_GREEN = 8'h14;
  localparam logic [7:0] ADR_BLUE = 8'h18;
  localparam logic [7:0] ADR_GREEN2 = 8'h1c;
  localparam logic [7:0] ADR_G2_EN = 8'h20;
  localparam logic [7:0] ADR_MODE = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;
  localparam logic [15:0] CLIP_MAX = 16'hffff; // Clip counter ceiling
endpackage

/* src/pgw_pix_if.sv */
`timescale 1ns/1ps
interface pgw_pix_if;
  logic in_valid; // Pixel present
  logic [11:0] in_pix; // Sensor value
  logic in_line_b; // Pixel from line B
  logic in_green; // Pixel is green
  logic [13:0] glob_gain; // Global gain setting
  logic [13:0] col_gain; // Selected colour gain
  logic signed [12:0] offset; // Offset in setting units
  pgw_pkg::pgw_mode_t mode; // Output depth
  logic out_valid; // Result present
  logic [11:0] out_pix; // Result value
  logic out_line_b; // Line tag passed on
  logic out_green; // Colour tag passed on
  logic out_clip; // Result was clamped
  modport src (output in_valid, in_pix, in_line_b, in_green, glob_gain, col_gain, offset, mode,
               input out_valid, out_pix, out_line_b, out_green, out_clip);
  modport dp (input in_valid, in_pix, in_line_b, in_green, glob_gain, col_gain, offset, mode,
              output out_valid, out_pix, out_line_b, out_green, out_clip);
endinterface

/* src/pgw_db_to_gain.sv */
`timescale 1ns/1ps
module pgw_db_to_gain (
  input wire logic i_clock, // Pixel clock
  input wire logic i_rst_b, // Sync reset, active low
  input wire logic i_start, // Convert i_db
  input wire logic signed [11:0] i_db, // Gain in 1/16 dB
  output logic o_done, // Result valid pulse
  output logic [13:0] o_gain // Integer setting
);
  // Log2 of the factor in Q12: dB / 6.0206
  logic signed [21:0] prod; // dB times scale
  logic signed [21:0] expo; // Q12 exponent
  logic signed [9:0] ipart; // Whole octaves
  logic [11:0] fpart; // Fraction of an octave
  logic [22:0] sq; // Curvature term
  logic [12:0] coef; // Slope plus curvature
  logic [24:0] mprod; // Fraction times slope
  logic [14:0] mant; // 2^f in Q12
  logic [14:0] scaled; // After octave shift
  logic [13:0] gain_next; // Clamped setting
  assign prod = 22'(i_db) * $signed(pgw_pkg::DB_TO_LOG2);
  assign expo = prod >>> 4;
  assign ipart = expo[21:12];
  assign fpart = expo[11:0];
  // Quadratic fit of 2^f keeps error under half a percent
  assign sq = 23'(fpart) * 23'(pgw_pkg::MANT_B);
  assign coef = pgw_pkg::MANT_A + 13'(sq[22:12]);
  assign mprod = 25'(fpart) * 25'(coef);
  assign mant = 15'(pgw_pkg::GAIN_UNITY) + 15'(mprod[24:12]);
  // Only one octave either side is in range, beyond that clamp
  assign scaled = (ipart > 10'sd1) ? 15'h7fff :
                  (ipart == 10'sd1) ? {mant[13:0], 1'b0} :
                  (ipart == 10'sd0) ? mant :
                  (ipart == -10'sd1) ? {1'b0, mant[14:1]} : 15'h0000;
  assign gain_next = (scaled > 15'(pgw_pkg::GAIN_MAX)) ? pgw_pkg::GAIN_MAX :
                     (scaled < 15'(pgw_pkg::GAIN_MIN)) ? pgw_pkg::GAIN_MIN : scaled[13:0];
  // Result register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
      o_gain <= pgw_pkg::GAIN_RST;
    end else begin
      o_done <= i_start;
      if (i_start) begin
        o_gain <= gain_next;
      end
    end
  end
endmodule

/* src/pgw_datapath.sv */
`timescale 1ns/1ps
module pgw_datapath (
  input wire logic i_clock, // Pixel clock
  input wire logic i_rst_b, // Sync reset, active low
  pgw_pix_if.dp p // Pixel stream in and out
);
  logic [13:0] geff; // Global gain as applied
  logic [27:0] gprod; // Global times colour
  logic [13:0] tot_next; // Total gain, clamped
  logic s1_valid_reg; // Stage 1 valid
  logic [11:0] s1_pix_reg; // Stage 1 pixel
  logic s1_line_b_reg; // Stage 1 line tag
  logic s1_green_reg; // Stage 1 colour tag
  logic [13:0] s1_tot_reg; // Stage 1 total gain
  logic signed [12:0] s1_ofs_reg; // Stage 1 offset
  pgw_pkg::pgw_mode_t s1_mode_reg; // Stage 1 depth
  logic [25:0] pprod; // Pixel times gain
  logic signed [15:0] sum; // Gained pixel plus offset
  logic [11:0] clamped; // Within 12-bit range
  logic [11:0] shifted; // At output depth
  // Above +6 dB global only when this colour adds no gain
  assign geff = (p.glob_gain > pgw_pkg::GAIN_NORM_MAX && p.col_gain > pgw_pkg::GAIN_UNITY) ?
                pgw_pkg::GAIN_NORM_MAX : p.glob_gain;
  // dB sum is the product of factors, capped at +12 dB
  assign gprod = 28'(geff) * 28'(p.col_gain);
  assign tot_next = (gprod[27:12] > 16'(pgw_pkg::GAIN_MAX)) ? pgw_pkg::GAIN_MAX : gprod[25:12];
  // Stage 1: gain pair resolved
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      s1_valid_reg <= 1'b0;
      s1_pix_reg <= 12'h000;
      s1_line_b_reg <= 1'b0;
      s1_green_reg <= 1'b0;
      s1_tot_reg <= pgw_pkg::GAIN_UNITY;
      s1_ofs_reg <= 13'sh0000;
      s1_mode_reg <= pgw_pkg::MODE_8;
    end else begin
      s1_valid_reg <= p.in_valid;
      s1_pix_reg <= p.in_pix;
      s1_line_b_reg <= p.in_line_b;
      s1_green_reg <= p.in_green;
      s1_tot_reg <= tot_next;
      s1_ofs_reg <= p.offset;
      s1_mode_reg <= p.mode;
    end
  end
  // Scale by setting / 4096, then offset on the 12-bit scale
  assign pprod = 26'(s1_pix_reg) * 26'(s1_tot_reg);
  assign sum = $signed({2'b00, pprod[25:12]}) + 16'(s1_ofs_reg);
  // Saturate instead of wrapping
  assign clamped = (sum < 16'sh0000) ? 12'h000 :
                   (sum > $signed({4'h0, pgw_pkg::PIX_MAX})) ? pgw_pkg::PIX_MAX : sum[11:0];
  // Low bits dropped so 16 or 4 units make one output count
  assign shifted = (s1_mode_reg == pgw_pkg::MODE_8) ? (clamped >> pgw_pkg::SHIFT_8) :
                   (s1_mode_reg == pgw_pkg::MODE_10) ? (clamped >> pgw_pkg::SHIFT_10) :
                   (clamped >> pgw_pkg::SHIFT_12);
  // Stage 2: result register
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      p.out_valid <= 1'b0;
      p.out_pix <= 12'h000;
      p.out_line_b <= 1'b0;
      p.out_green <= 1'b0;
      p.out_clip <= 1'b0;
    end else begin
      p.out_valid <= s1_valid_reg;
      p.out_pix <= shifted;
      p.out_line_b <= s1_line_b_reg;
      p.out_green <= s1_green_reg;
      p.out_clip <= s1_valid_reg && (sum < 16'sh0000 || sum > 16'sh0fff);
    end
  end
endmodule

/* src/pgw_top.sv */
// Summary of operation
// - One global gain scales all colours
// - Global gain minimum 2731, reset 4096
// - Factor equals setting divided by 4096
// - Global gain normally capped at 8192
// - Up to 16383 only with colour gain at most 4096
// - Total gain is global times colour factor
// - 8-bit: offset +-255, 16 per count
// - 10-bit: offset +-1023, 4 per count
// - 12-bit: offset +-4095, 1 per count
// - Global gain writable in dB or integer
// - Offset writable in counts or integer
// - Red and blue gains hit own colour
// - Green gain covers both lines when shared
// - Separate line B green when enabled
// - Reset colour gains 4096, 6144, 8192
// - Separate line B green off after reset
// - Colour gains use the same 4096 scale
// - Colour gains kept within 2731 to 16383
// - Line A red/green, line B green/blue
// - Line B green starts from green gain
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module pgw_top (
  input wire logic i_clock, // 200 MHz pixel clock
  input wire logic i_rst_b, // Sync reset, active low
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Bus strobe
  input wire logic i_wb_we, // Write when high
  input wire logic [7:0] i_wb_adr, // Byte address
  input wire logic [3:0] i_wb_sel, // Byte lanes
  input wire logic [31:0] i_wb_dat, // Write data
  output logic [31:0] o_wb_dat, // Read data
  output logic o_wb_ack, // Access done
  input wire logic i_pix_valid, // Sensor pixel present
  input wire logic [11:0] i_pix_data, // Sensor pixel value
  input wire logic i_pix_line_b, // Pixel from line B
  input wire logic i_pix_green, // Pixel is green
  output logic o_pix_valid, // Result present
  output logic [11:0] o_pix_data, // Result, low bits used
  output logic o_pix_line_b, // Line tag of result
  output logic o_pix_green // Colour tag of result
);
  // Setting registers
  logic [13:0] gain_reg; // Global gain setting
  logic signed [11:0] gain_db_reg; // Last dB written
  logic signed [12:0] ofs_reg; // Offset in setting units
  logic [13:0] red_reg; // Red extra gain
  logic [13:0] green_reg; // Green extra gain
  logic [13:0] blue_reg; // Blue extra gain
  logic [13:0] green2_reg; // Line B green extra gain
  logic g2_en_reg; // Line B green gain in use
  pgw_pkg::pgw_mode_t mode_reg; // Output depth
  logic [15:0] clip_cnt_reg; // Clamped results seen
  logic db_start_reg; // Conversion request
  logic ack_reg; // Bus answer
  logic [31:0] rdat_reg; // Read data held
  // Converter results
  logic db_done; // Converted gain ready
  logic [13:0] db_gain; // Converted gain
  // Pixel stream into the arithmetic stage, declared before the clip counter reads it
  pgw_pix_if pix ();

  // Bus decode
  wire access = i_wb_cyc && i_wb_stb && !ack_reg; // New request this cycle
  wire wr = access && i_wb_we; // Write takes effect with ack
  wire [31:0] sel_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire hit_gain = (i_wb_adr == pgw_pkg::ADR_GAIN_RAW); // Integer gain
  wire hit_db = (i_wb_adr == pgw_pkg::ADR_GAIN_DB); // dB gain
  wire hit_ofs = (i_wb_adr == pgw_pkg::ADR_OFS_RAW); // Integer offset
  wire hit_dn = (i_wb_adr == pgw_pkg::ADR_OFS_DN); // Offset in counts
  wire hit_red = (i_wb_adr == pgw_pkg::ADR_RED); // Red gain
  wire hit_green = (i_wb_adr == pgw_pkg::ADR_GREEN); // Green gain
  wire hit_blue = (i_wb_adr == pgw_pkg::ADR_BLUE); // Blue gain
  wire hit_green2 = (i_wb_adr == pgw_pkg::ADR_GREEN2); // Line B green
  wire hit_g2_en = (i_wb_adr == pgw_pkg::ADR_G2_EN); // Line B enable
  wire hit_mode = (i_wb_adr == pgw_pkg::ADR_MODE); // Depth select
  wire hit_status = (i_wb_adr == pgw_pkg::ADR_STATUS); // Clip counter

  // Offset in output counts: setting shifted by the mode's step
  wire [3:0] ofs_shift = (mode_reg == pgw_pkg::MODE_8) ? pgw_pkg::SHIFT_8 :
                         (mode_reg == pgw_pkg::MODE_10) ? pgw_pkg::SHIFT_10 : pgw_pkg::SHIFT_12;
  wire [12:0] ofs_lim = (mode_reg == pgw_pkg::MODE_8) ? pgw_pkg::OFS_LIM_8 :
                        (mode_reg == pgw_pkg::MODE_10) ? pgw_pkg::OFS_LIM_10 : pgw_pkg::OFS_LIM_12;
  wire signed [12:0] ofs_dn = ofs_reg >>> ofs_shift; // Counts view of offset

  // Read mux, also the base for byte-lane merging
  wire [31:0] rd_word = hit_gain ? {18'h00000, gain_reg} :
                        hit_db ? {{20{gain_db_reg[11]}}, gain_db_reg} :
                        hit_ofs ? {{19{ofs_reg[12]}}, ofs_reg} :
                        hit_dn ? {{19{ofs_dn[12]}}, ofs_dn} :
                        hit_red ? {18'h00000, red_reg} :
                        hit_green ? {18'h00000, green_reg} :
                        hit_blue ? {18'h00000, blue_reg} :
                        hit_green2 ? {18'h00000, green2_reg} :
                        hit_g2_en ? {31'h00000000, g2_en_reg} :
                        hit_mode ? {30'h00000000, mode_reg} :
                        hit_status ? {16'h0000, clip_cnt_reg} : 32'h00000000;
  wire [31:0] wval = (rd_word & ~sel_mask) | (i_wb_dat & sel_mask); // Merged write word

  // Gain writes saturate to the legal setting range
  function automatic logic [13:0] sat_gain(input logic [31:0] v);
    logic [13:0] r;
    r = v[13:0];
    if (v[31] || v > 32'(pgw_pkg::GAIN_MAX)) begin
      r = (v[31]) ? pgw_pkg::GAIN_MIN : pgw_pkg::GAIN_MAX;
    end else if (v < 32'(pgw_pkg::GAIN_MIN)) begin
      r = pgw_pkg::GAIN_MIN;
    end
    return r;
  endfunction

  // Offset writes saturate to the current mode's span
  function automatic logic signed [12:0] sat_ofs(input logic signed [31:0] v, input logic [12:0] lim);
    logic signed [12:0] r;
    r = v[12:0];
    if (v > $signed(32'(lim))) begin
      r = $signed(lim);
    end else if (v < -$signed(32'(lim))) begin
      r = -$signed(lim);
    end
    return r;
  endfunction

  wire [13:0] gain_wr = sat_gain(wval); // Clamped gain write
  wire signed [12:0] ofs_wr = sat_ofs($signed(wval), ofs_lim); // Integer offset write
  wire signed [31:0] dn_units = $signed(wval) <<< ofs_shift; // Counts to units
  wire signed [12:0] dn_wr = sat_ofs(dn_units, ofs_lim); // Counts offset write
  wire mode_ok = (wval[1:0] != 2'h3); // Defined depth code

  // Colour select: line A holds red/green, line B green/blue
  wire [13:0] green_sel = (i_pix_line_b && g2_en_reg) ? green2_reg : green_reg;
  wire [13:0] col_sel = i_pix_green ? green_sel :
                        (i_pix_line_b ? blue_reg : red_reg);

  // Bus answer: one cycle after the strobe, dropped the next cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= access;
      if (access) begin
        // Unmapped addresses read zero
        rdat_reg <= rd_word;
      end
    end
  end

  // Global gain, integer path or converted dB path
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      gain_reg <= pgw_pkg::GAIN_RST;
      gain_db_reg <= pgw_pkg::DB_RST;
      db_start_reg <= 1'b0;
    end else begin
      db_start_reg <= wr && hit_db;
      if (wr && hit_gain) begin
        // Integer form, kept within 2731 to 16383
        gain_reg <= gain_wr;
      end else if (db_done) begin
        // dB form lands two cycles after the write
        gain_reg <= db_gain;
      end
      if (wr && hit_db) begin
        gain_db_reg <= wval[11:0];
      end
    end
  end

  // Offset, either form saturated to the mode's span
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ofs_reg <= 13'sh0000;
    end else if (wr && hit_ofs) begin
      ofs_reg <= ofs_wr;
    end else if (wr && hit_dn) begin
      ofs_reg <= dn_wr;
    end
  end

  // Colour gains
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      red_reg <= pgw_pkg::RED_RST;
      green_reg <= pgw_pkg::GREEN_RST;
      blue_reg <= pgw_pkg::BLUE_RST;
    end else if (wr) begin
      if (hit_red) begin
        red_reg <= gain_wr;
      end
      if (hit_green) begin
        green_reg <= gain_wr;
      end
      if (hit_blue) begin
        blue_reg <= gain_wr;
      end
    end
  end

  // Line B green: copies green on enabling, kept when disabled
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      g2_en_reg <= 1'b0;
      green2_reg <= pgw_pkg::GREEN_RST;
    end else if (wr && hit_g2_en) begin
      g2_en_reg <= wval[0];
      if (wval[0] && !g2_en_reg) begin
        green2_reg <= green_reg;
      end
    end else if (wr && hit_green2) begin
      green2_reg <= gain_wr;
    end
  end

  // Output depth; undefined code is ignored
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mode_reg <= pgw_pkg::pgw_mode_t'(pgw_pkg::MODE_RST);
    end else if (wr && hit_mode && mode_ok) begin
      mode_reg <= pgw_pkg::pgw_mode_t'(wval[1:0]);
    end
  end

  // Clip counter: a clamp in the clearing cycle still counts
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      clip_cnt_reg <= 16'h0000;
    end else if (wr && hit_status) begin
      clip_cnt_reg <= {15'h0000, pix.out_clip};
    end else if (pix.out_clip && clip_cnt_reg != pgw_pkg::CLIP_MAX) begin
      clip_cnt_reg <= clip_cnt_reg + 16'h0001;
    end
  end

  // dB to integer converter
  pgw_db_to_gain u_db (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_start(db_start_reg),
    .i_db(gain_db_reg),
    .o_done(db_done),
    .o_gain(db_gain)
  );

  // Pixel stream into the arithmetic stage
  assign pix.in_valid = i_pix_valid;
  assign pix.in_pix = i_pix_data;
  assign pix.in_line_b = i_pix_line_b;
  assign pix.in_green = i_pix_green;
  assign pix.glob_gain = gain_reg;
  assign pix.col_gain = col_sel;
  assign pix.offset = ofs_reg;
  assign pix.mode = mode_reg;

  // Two-stage gain, offset and clamp
  pgw_datapath u_dp (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .p(pix.dp)
  );

  // Outputs straight from the bus and datapath flops
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  assign o_pix_valid = pix.out_valid;
  assign o_pix_data = pix.out_pix;
  assign o_pix_line_b = pix.out_line_b;
  assign o_pix_green = pix.out_green;
endmodule

/* tb/pgw_checker.sv */
`timescale 1ns/1ps
module pgw_checker (
  input wire logic i_clock, // Clock
  input wire logic i_rst_b, // Reset, active low
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Bus strobe
  input wire logic i_wb_we, // Write
  input wire logic [7:0] i_wb_adr, // Address
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack, // Answer
  input wire logic i_pix_valid, // Pixel in
  input wire logic i_pix_line_b, // Line tag in
  input wire logic o_pix_valid, // Pixel out
  input wire logic [11:0] o_pix_data, // Result
  input wire logic o_pix_line_b // Line tag out
);
  logic [1:0] mode_q; // Own copy of output depth
  wire take = i_wb_cyc & i_wb_stb & ~o_wb_ack; // Request taken this edge
  wire mode_wr = take & i_wb_we & (i_wb_adr == pgw_pkg::ADR_MODE) & (i_wb_dat[1:0] != 2'h3); // Value 3 ignored
  // Track mode so depth checks need no access to internals
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) mode_q <= pgw_pkg::MODE_RST;
    else if (mode_wr) mode_q <= i_wb_dat[1:0];
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_read(logic [7:0] a);
    s_take ##0 (!i_wb_we && i_wb_adr == a);
  endsequence
  ack_one_cycle_a: assert property (s_take |=> o_wb_ack) else $error("ack late");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  unmapped_zero_a: assert property (s_read(8'h30) |=> o_wb_dat == 32'h0) else $error("unmapped nonzero");
  mode_read_a: assert property (s_read(pgw_pkg::ADR_MODE) |=> o_wb_dat[1:0] == mode_q) else $error("mode bad");
  pix_latency_a: assert property (i_pix_valid |-> ##2 o_pix_valid) else $error("pixel lost");
  no_extra_pix_a: assert property (!i_pix_valid |-> ##2 !o_pix_valid) else $error("extra pixel");
  line_tag_a: assert property (i_pix_valid |-> ##2 (o_pix_line_b == $past(i_pix_line_b, 2))) else $error("tag");
  depth_8_a: assert property (o_pix_valid && $past(mode_q, 2) == 2'h0
    |-> o_pix_data[11:8] == 4'h0) else $error("8-bit overrun");
  depth_10_a: assert property (o_pix_valid && $past(mode_q, 2) == 2'h1
    |-> o_pix_data[11:10] == 2'h0) else $error("10-bit overrun");
endmodule

/* tb/pgw_sensor_model.sv */
`timescale 1ns/1ps
module pgw_sensor_model (
  input wire logic i_clock, // Clock
  input wire logic i_run, // Emit a pixel
  input wire logic i_line_b, // Line of next pixel
  input wire logic [11:0] i_value, // Next pixel value
  output logic o_valid, // Pixel present
  output logic [11:0] o_data, // Pixel value
  output logic o_line_b, // Line tag
  output logic o_green // Green tag
);
  logic phase; // Colour and green pixels alternate
  initial begin
    {o_valid, o_data, o_line_b, o_green, phase} = '0;
  end
  // Line A holds red/green, line B green/blue; idle data inverts so stale values never match
  always @(posedge i_clock) begin
    o_valid <= i_run;
    o_data <= i_run ? i_value : ~o_data;
    o_line_b <= i_line_b;
    o_green <= i_run ? phase : ~o_green;
    if (i_run) phase <= ~phase;
  end
endmodule

/* tb/pgw_top_bench.sv */
`timescale 1ns/1ps
module pgw_top_bench;
  logic i_clock = 1'b0, i_rst_b = 1'b0; // Clock and reset
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0; // Bus request
  logic [7:0] i_wb_adr = 8'h00; // Address
  logic [3:0] i_wb_sel = 4'hf; // All lanes
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q; // Data and last read
  logic o_wb_ack, i_pix_valid, i_pix_line_b, i_pix_green, o_pix_valid, o_pix_line_b, o_pix_green;
  logic [11:0] i_pix_data, o_pix_data, val = 12'h000; // Pixel values
  logic run = 1'b0, lnb = 1'b0, sen; // Sensor control, shadow enable
  logic [13:0] sg, sr, sgr, sb, sg2; // Shadow gains
  logic [1:0] sm; // Shadow mode
  logic signed [12:0] so; // Shadow offset
  logic [12:0] expq[$]; // Expected green tag and pixel, oldest first
  int n_fail = 0, checks_done = 0;
  int sh[3] = '{4, 2, 0}, lim[3] = '{255, 1023, 4095}; // Per mode shift and offset span
  logic [7:0] ra[8] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h08};
  logic [31:0] rv[8] = '{32'h1000, 32'h1000, 32'h1800, 32'h2000, 32'h1800, 32'h0, 32'h0, 32'h0};
  initial forever #2.5 i_clock = ~i_clock;
  pgw_top u_dut (.i_clock, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_pix_valid, .i_pix_data, .i_pix_line_b, .i_pix_green, .o_pix_valid,
    .o_pix_data, .o_pix_line_b, .o_pix_green);
  pgw_sensor_model u_sensor (.i_clock, .i_run(run), .i_line_b(lnb), .i_value(val), .o_valid(i_pix_valid),
    .o_data(i_pix_data), .o_line_b(i_pix_line_b), .o_green(i_pix_green));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, seen, want);
    end
  endtask
  // Gain writes saturate into the legal span
  function automatic logic [13:0] sat(input logic [31:0] v);
    if (v < 32'h0aab) return pgw_pkg::GAIN_MIN;
    if (v > 32'h3fff) return pgw_pkg::GAIN_MAX;
    return v[13:0];
  endfunction
  function automatic logic [11:0] expv(input logic [11:0] d, input logic lb, input logic gr);
    logic [13:0] c;
    logic [13:0] ge;
    int t;
    int r;
    c = gr ? ((lb && sen) ? sg2 : sgr) : (lb ? sb : sr);
    ge = (sg > pgw_pkg::GAIN_NORM_MAX && c > pgw_pkg::GAIN_UNITY) ? pgw_pkg::GAIN_NORM_MAX : sg;
    t = (int'(ge) * int'(c)) >>> 12;
    if (t > 32'h3fff) t = 32'h3fff;
    r = ((int'(d) * t) >>> 12) + int'(so);
    if (r < 0) r = 0;
    if (r > 32'hfff) r = 32'hfff;
    return 12'(r >>> sh[sm]);
  endfunction
  // Classic cycle: hold until ack is sampled, then release for one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, w, a, d};
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      stop_test();
    end
    q = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // Write and keep the shadow settings in step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    case (a)
      pgw_pkg::ADR_GAIN_RAW: sg = sat(d);
      pgw_pkg::ADR_RED: sr = sat(d);
      pgw_pkg::ADR_GREEN: sgr = sat(d);
      pgw_pkg::ADR_BLUE: sb = sat(d);
      pgw_pkg::ADR_GREEN2: sg2 = sat(d);
      pgw_pkg::ADR_OFS_RAW: so = d[12:0];
      pgw_pkg::ADR_OFS_DN: so = 13'(int'($signed(d)) <<< sh[sm]);
      pgw_pkg::ADR_G2_EN: begin
        if (d[0] && !sen) sg2 = sgr;
        sen = d[0];
      end
      pgw_pkg::ADR_MODE: if (d[1:0] != 2'h3) sm = d[1:0];
      default: ;
    endcase
  endtask
  // Random pixels on both lines, full scale now and then to force clamping
  task automatic px(input int n);
    repeat (n) begin
      run <= 1'b1;
      lnb <= 1'($urandom);
      val <= ($urandom % 4 == 0) ? 12'hfff : 12'($urandom);
      @(posedge i_clock);
    end
    run <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask
  always @(posedge i_clock) begin
    if (i_rst_b === 1'b1 && i_pix_valid === 1'b1)
      expq.push_back({i_pix_green, expv(i_pix_data, i_pix_line_b, i_pix_green)});
  end
  always @(posedge i_clock) begin
    if (o_pix_valid === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else chk(32'({o_pix_green, o_pix_data}), 32'(expq.pop_front()));
    end
  end
  initial begin
    void'($urandom(9993));
    {sg, sr, sgr, sb, sg2} = {pgw_pkg::GAIN_RST, pgw_pkg::RED_RST, pgw_pkg::GREEN_RST, pgw_pkg::BLUE_RST,
      pgw_pkg::GREEN_RST};
    {sen, sm, so} = '0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(q, rv[i]);
    end
    wr(8'h30, 32'h1234);
    rd(8'h30);
    chk(q, 32'h0);
    px(40);
    $display("test reset and default stream done");
    // Gains up to 8192 with colour gains at most 8192 keep totals in bounds
    for (int m = 0; m < 3; m++) begin
      wr(pgw_pkg::ADR_MODE, 32'(m));
      for (int s = -1; s < 2; s += 2) begin
        wr(pgw_pkg::ADR_OFS_DN, 32'(s));
        rd(pgw_pkg::ADR_OFS_RAW);
        chk(q, 32'(s <<< sh[m]));
      end
      wr(pgw_pkg::ADR_GAIN_RAW, 32'h0aab + $urandom % 32'h1556);
      wr(pgw_pkg::ADR_OFS_RAW, 32'(int'($urandom % (2 * lim[m] + 1)) - lim[m]));
      px(40);
    end
    $display("test modes and offsets done");
    wr(pgw_pkg::ADR_GAIN_DB, 32'h60);
    rd(pgw_pkg::ADR_GAIN_RAW);
    chk(32'(q > 32'h1fd5 && q < 32'h2031), 32'h1);
    sg = q[13:0];
    wr(pgw_pkg::ADR_GAIN_RAW, 32'h5);
    wr(pgw_pkg::ADR_RED, 32'h5);
    rd(pgw_pkg::ADR_GAIN_RAW);
    chk(q, 32'h0aab);
    rd(pgw_pkg::ADR_RED);
    chk(q, 32'h0aab);
    wr(pgw_pkg::ADR_RED, 32'h1000);
    wr(pgw_pkg::ADR_GAIN_RAW, 32'h3fff);
    px(30);
    $display("test gain limits done");
    wr(pgw_pkg::ADR_GAIN_RAW, 32'h1000);
    wr(pgw_pkg::ADR_GREEN, 32'h1388);
    wr(pgw_pkg::ADR_G2_EN, 32'h1);
    rd(pgw_pkg::ADR_GREEN2);
    chk(q, 32'h1388);
    wr(pgw_pkg::ADR_GREEN2, 32'h0bb8);
    px(30);
    wr(pgw_pkg::ADR_G2_EN, 32'h0);
    px(20);
    wr(pgw_pkg::ADR_MODE, 32'h3);
    rd(pgw_pkg::ADR_MODE);
    chk(q, 32'(sm));
    $display("test separate green done");
    stop_test();
  end
endmodule
bind pgw_top pgw_checker u_chk (.i_clock, .i_rst_b, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .i_pix_valid, .i_pix_line_b, .o_pix_valid, .o_pix_data, .o_pix_line_b);
